// ===== hw/qfa_regs.svh
// constants of the quad spi flash array access block
`ifndef QFA_REGS_SVH
`define QFA_REGS_SVH
// command codes
`define QFA_CMD_QOUT_READ 8'h6b
`define QFA_CMD_QIO_READ 8'heb
`define QFA_CMD_PAGE_WRITE 8'h02
`define QFA_CMD_QPAGE_WRITE 8'h32
`define QFA_CMD_SECTOR_WIPE 8'h20
`define QFA_CMD_WRITE_UNLOCK 8'h06
`define QFA_CMD_WRITE_LOCK 8'h04
`define QFA_CMD_SET_WRAP 8'h77
// phase lengths in bits or clocks, continuous mode value, wrap off bit and fifo depth
`define QFA_ADDR_BITS 6'h18
`define QFA_BYTE_BITS 6'h08
`define QFA_QOUT_DUMMY 6'h08
`define QFA_QIO_DUMMY_SHORT 6'h06
`define QFA_QIO_DUMMY_LONG 6'h0a
`define QFA_MODE_CLOCKS 6'h02
`define QFA_CONT_MODE 2'h2
`define QFA_WRAP_OFF_BIT 4
`define QFA_FIFO_DEPTH 16
// timing
`define QFA_CLK_PERIOD_NS 4
`define QFA_PAGE_WRITE_TIME_US 1000
`define QFA_SECTOR_WIPE_TIME_US 100000
`endif

// ===== hw/qfa_pkg.sv
// types of the quad spi flash array access block
package qfa_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_DOUT,
    ST_PROG, ST_ERASE, ST_WRAP, ST_SKIP
  } qfa_state_t;
  typedef enum logic [2:0] {
    K_QOUT, K_QIO, K_PAGE, K_QPAGE, K_WIPE
  } qfa_kind_t;
  typedef struct packed {
    logic [23:0] addr;
    logic [7:0] data;
  } qfa_wr_t;
endpackage

// ===== hw/qfa_top.sv
// quad spi flash array access: command sequencer and program fifo
`timescale 1ns/1ps
`include "qfa_regs.svh"
`default_nettype none

// ==========================================
// fifo between page walker and array port
module qfa_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_ptr_reg, rd_ptr_reg;
  wire full_w = (wr_ptr_reg ^ rd_ptr_reg) == {1'b1, {AW{1'b0}}};
  wire empty_w = wr_ptr_reg == rd_ptr_reg;
  wire push_w = in_valid_i && !full_w;
  wire pop_w = out_ready_i && !empty_w;
  // status and read data
  assign in_ready_o = !full_w;
  assign out_valid_o = !empty_w;
  assign out_data_o = mem_reg[rd_ptr_reg[AW-1:0]];
  // storage has no reset, pointers do
  always_ff @(posedge clock_i) begin
    if (push_w) mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
  end
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push_w) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop_w) rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule // qfa_fifo

// ==========================================
// device top
module qfa_top import qfa_pkg::*; #(
  parameter int unsigned PAGE_WRITE_CYCLES =
    (`QFA_PAGE_WRITE_TIME_US * 1000) / `QFA_CLK_PERIOD_NS,
  parameter int unsigned SECTOR_WIPE_CYCLES =
    (`QFA_SECTOR_WIPE_TIME_US * 1000) / `QFA_CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // serial pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic [3:0] lane_i,
  output logic [3:0] lane_o,
  output logic [3:0] lane_oe_o,
  // status bits
  input wire logic quad_lane_enable_bit_i,
  input wire logic dummy_cycle_select_bit_i,
  input wire logic [4:0] block_protect_field_i,
  output logic write_unlock_latch_o,
  output logic busy_writing_flag_o,
  // array read port
  output logic arr_rd_req_o,
  output logic [23:0] arr_rd_addr_o,
  input wire logic [7:0] arr_rd_data_i,
  input wire logic arr_rd_valid_i,
  // array program port
  output logic arr_wr_valid_o,
  output qfa_wr_t arr_wr_o,
  input wire logic arr_wr_ready_i,
  // array erase port
  output logic erase_req_o,
  output logic [23:0] erase_addr_o
);
  // ==========================================
  // pin synchronisers
  logic [2:0] cs_sync_reg, sclk_sync_reg;
  logic [3:0] lane_s1_reg, lane_s2_reg;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cs_sync_reg <= 3'h7;
      sclk_sync_reg <= 3'h0;
      lane_s1_reg <= 4'h0;
      lane_s2_reg <= 4'h0;
    end else begin
      cs_sync_reg <= {cs_sync_reg[1:0], cs_n_i};
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_i};
      lane_s1_reg <= lane_i;
      lane_s2_reg <= lane_s1_reg;
    end
  end
  // edges seen after the second stage only
  wire cs_hi = cs_sync_reg[1];
  wire cs_fall_e = !cs_sync_reg[1] && cs_sync_reg[2];
  wire cs_rise_e = cs_sync_reg[1] && !cs_sync_reg[2];
  wire rise_e = sclk_sync_reg[1] && !sclk_sync_reg[2] && !cs_hi;
  wire fall_e = !sclk_sync_reg[1] && sclk_sync_reg[2] && !cs_hi;

  // ==========================================
  // state
  qfa_state_t state_reg, state_next;
  qfa_kind_t kind_reg, kind_next;
  logic [5:0] cnt_reg, cnt_nx;
  logic [31:0] sh_reg;
  logic [23:0] addr_reg;
  logic [7:0] off_reg;
  logic cont_reg, unlock_reg, busy_reg, any_byte_reg;
  logic wrap_en_reg;
  logic [1:0] wrap_len_reg;
  logic [7:0] pbuf_reg [256];
  logic [255:0] mask_reg;

  // protection: bp[2:0] sets size, bp[3] bottom, bp[4] 4k granules
  function automatic logic prot_hit(input logic [23:0] a,
                                    input logic [4:0] bp);
    logic [19:0] sz;
    logic [19:0] off;
    begin
      sz = bp[4] ? (20'h01000 << (bp[2:0] - 3'h1))
                 : (20'h10000 << (bp[2:0] - 3'h1));
      off = bp[3] ? a[19:0] : ~a[19:0];
      prot_hit = (bp[2:0] != 3'h0) && ((bp[2:0] > 3'h4) || (off < sz));
    end
  endfunction

  // lane width and shift decode
  wire quad_w = (kind_reg == K_QIO && (state_reg == ST_ADDR ||
                 state_reg == ST_DUMMY)) ||
                (kind_reg == K_QPAGE && state_reg == ST_PROG);
  wire [31:0] sh_next = quad_w ? {sh_reg[27:0], lane_s2_reg}
                               : {sh_reg[30:0], lane_s2_reg[0]};
  wire [5:0] step_w = (quad_w && state_reg != ST_DUMMY) ? 6'h04 : 6'h01;
  wire [5:0] cnt_inc = cnt_reg + step_w;
  wire [7:0] cmd_w = sh_next[7:0];
  wire [5:0] dummy_tgt = (kind_reg != K_QIO) ? `QFA_QOUT_DUMMY :
    (dummy_cycle_select_bit_i ? `QFA_QIO_DUMMY_LONG : `QFA_QIO_DUMMY_SHORT);
  wire cmd_done = rise_e && state_reg == ST_CMD &&
                  cnt_inc == `QFA_BYTE_BITS && !busy_reg;
  wire addr_done = rise_e && state_reg == ST_ADDR &&
                   cnt_inc == `QFA_ADDR_BITS;
  wire dout_enter = rise_e && state_reg == ST_DUMMY && cnt_inc == dummy_tgt;
  wire byte_in = rise_e && state_reg == ST_PROG && cnt_inc == `QFA_BYTE_BITS;
  wire prot_w = prot_hit(addr_reg, block_protect_field_i);
  wire prog_go = cs_rise_e && state_reg == ST_PROG && cnt_reg == 6'h00 &&
                 any_byte_reg && unlock_reg && !busy_reg && !prot_w;
  wire wipe_go = cs_rise_e && state_reg == ST_ERASE && unlock_reg &&
                 !busy_reg && !prot_w;

  // ==========================================
  // command sequencer
  always_comb begin
    state_next = state_reg;
    kind_next = kind_reg;
    cnt_nx = cnt_reg;
    if (cs_fall_e) begin
      cnt_nx = 6'h00;
      if (cont_reg && !busy_reg && quad_lane_enable_bit_i) begin
        state_next = ST_ADDR;
        kind_next = K_QIO;
      end else begin
        state_next = ST_CMD;
      end
    end else if (cs_hi) begin
      state_next = ST_IDLE;
    end else if (rise_e) begin
      cnt_nx = cnt_inc;
      case (state_reg)
        ST_CMD: begin
          if (cnt_inc == `QFA_BYTE_BITS) begin
            cnt_nx = 6'h00;
            state_next = ST_SKIP;
            if (!busy_reg) begin
              case (cmd_w)
                `QFA_CMD_QOUT_READ: begin
                  state_next = ST_ADDR;
                  kind_next = K_QOUT;
                end
                `QFA_CMD_QIO_READ: begin
                  if (quad_lane_enable_bit_i) begin
                    state_next = ST_ADDR;
                    kind_next = K_QIO;
                  end
                end
                `QFA_CMD_PAGE_WRITE: begin
                  if (unlock_reg) begin
                    state_next = ST_ADDR;
                    kind_next = K_PAGE;
                  end
                end
                `QFA_CMD_QPAGE_WRITE: begin
                  if (unlock_reg && quad_lane_enable_bit_i) begin
                    state_next = ST_ADDR;
                    kind_next = K_QPAGE;
                  end
                end
                `QFA_CMD_SECTOR_WIPE: begin
                  if (unlock_reg) begin
                    state_next = ST_ADDR;
                    kind_next = K_WIPE;
                  end
                end
                `QFA_CMD_SET_WRAP: state_next = ST_WRAP;
                default: state_next = ST_SKIP;
              endcase
            end
          end
        end
        ST_ADDR: begin
          if (cnt_inc == `QFA_ADDR_BITS) begin
            cnt_nx = 6'h00;
            case (kind_reg)
              K_QOUT, K_QIO: state_next = ST_DUMMY;
              K_PAGE, K_QPAGE: state_next = ST_PROG;
              default: state_next = ST_ERASE;
            endcase
          end
        end
        ST_DUMMY: begin
          if (cnt_inc == dummy_tgt) begin
            cnt_nx = 6'h00;
            state_next = ST_DOUT;
          end
        end
        ST_PROG: if (cnt_inc == `QFA_BYTE_BITS) cnt_nx = 6'h00;
        ST_ERASE: state_next = ST_SKIP;
        ST_WRAP: if (cnt_inc == `QFA_BYTE_BITS) state_next = ST_SKIP;
        default: cnt_nx = cnt_reg;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_reg <= ST_IDLE;
      kind_reg <= K_QOUT;
      cnt_reg <= 6'h00;
      sh_reg <= 32'h0;
    end else begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      cnt_reg <= cnt_nx;
      if (rise_e) sh_reg <= sh_next;
    end
  end

  // ==========================================
  // address, mode, wrap and latch
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      addr_reg <= 24'h0;
      cont_reg <= 1'b0;
      wrap_en_reg <= 1'b0;
      wrap_len_reg <= 2'h0;
    end else begin
      if (addr_done) addr_reg <= sh_next[23:0];
      if (rise_e && state_reg == ST_DUMMY && kind_reg == K_QIO &&
          cnt_inc == `QFA_MODE_CLOCKS)
        cont_reg <= sh_next[5:4] == `QFA_CONT_MODE;
      if (rise_e && state_reg == ST_WRAP && cnt_inc == `QFA_BYTE_BITS) begin
        wrap_en_reg <= !sh_next[`QFA_WRAP_OFF_BIT];
        wrap_len_reg <= sh_next[6:5];
      end
    end
  end

  // start of a timed cycle beats a late unlock
  always_ff @(posedge clock_i) begin
    if (srst_i) unlock_reg <= 1'b0;
    else if (prog_go || wipe_go) unlock_reg <= 1'b0;
    else if (cmd_done && cmd_w == `QFA_CMD_WRITE_UNLOCK) unlock_reg <= 1'b1;
    else if (cmd_done && cmd_w == `QFA_CMD_WRITE_LOCK) unlock_reg <= 1'b0;
  end

  // ==========================================
  // page buffer: offset wraps inside the page
  wire prog_start = cmd_done && unlock_reg &&
                    (cmd_w == `QFA_CMD_PAGE_WRITE ||
                     cmd_w == `QFA_CMD_QPAGE_WRITE);
  always_ff @(posedge clock_i) begin
    if (byte_in) pbuf_reg[off_reg] <= sh_next[7:0];
  end
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      mask_reg <= '0;
      off_reg <= 8'h00;
      any_byte_reg <= 1'b0;
    end else if (prog_start) begin
      mask_reg <= '0;
      any_byte_reg <= 1'b0;
    end else begin
      if (addr_done) off_reg <= sh_next[7:0];
      if (byte_in) begin
        mask_reg[off_reg] <= 1'b1;
        off_reg <= off_reg + 8'h01;
        any_byte_reg <= 1'b1;
      end
    end
  end

  // ==========================================
  // walker pushes marked bytes into the fifo
  logic walk_act_reg;
  logic [7:0] walk_idx_reg;
  logic fifo_in_ready, fifo_out_valid, wr_valid_reg;
  qfa_wr_t fifo_out, wr_reg;
  qfa_wr_t push_data;
  wire push_valid = walk_act_reg && mask_reg[walk_idx_reg];
  wire walk_adv = walk_act_reg && (!mask_reg[walk_idx_reg] || fifo_in_ready);
  wire out_take = !wr_valid_reg || arr_wr_ready_i;
  assign push_data = '{addr: {addr_reg[23:8], walk_idx_reg},
                       data: pbuf_reg[walk_idx_reg]};

  qfa_fifo #(.WIDTH($bits(qfa_wr_t)), .DEPTH(`QFA_FIFO_DEPTH)) u_fifo (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .in_valid_i(push_valid),
    .in_data_i(push_data),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out),
    .out_ready_i(out_take)
  );

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      walk_act_reg <= 1'b0;
      walk_idx_reg <= 8'h00;
    end else if (prog_go) begin
      walk_act_reg <= 1'b1;
      walk_idx_reg <= 8'h00;
    end else if (walk_adv) begin
      walk_idx_reg <= walk_idx_reg + 8'h01;
      if (walk_idx_reg == 8'hff) walk_act_reg <= 1'b0;
    end
  end

  // output stage keeps the port on flops
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wr_valid_reg <= 1'b0;
      wr_reg <= '0;
    end else if (out_take) begin
      wr_valid_reg <= fifo_out_valid;
      wr_reg <= fifo_out;
    end
  end

  // ==========================================
  // busy timer; busy also covers draining
  logic [31:0] tmr_reg;
  logic erase_req_reg;
  logic [23:0] erase_addr_reg;
  wire drained = !walk_act_reg && !fifo_out_valid && !wr_valid_reg;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      busy_reg <= 1'b0;
      tmr_reg <= 32'h0;
    end else if (prog_go || wipe_go) begin
      busy_reg <= 1'b1;
      tmr_reg <= prog_go ? 32'(PAGE_WRITE_CYCLES) : 32'(SECTOR_WIPE_CYCLES);
    end else if (busy_reg) begin
      if (tmr_reg != 32'h0) tmr_reg <= tmr_reg - 32'h1;
      else if (drained) busy_reg <= 1'b0;
    end
  end

  // sector base of any address given
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      erase_req_reg <= 1'b0;
      erase_addr_reg <= 24'h0;
    end else begin
      erase_req_reg <= wipe_go;
      if (wipe_go) erase_addr_reg <= {addr_reg[23:12], 12'h000};
    end
  end

  // ==========================================
  // read data path; one byte prefetched ahead
  logic rd_req_reg, half_reg;
  logic [23:0] rd_addr_reg;
  logic [7:0] nxt_reg;
  logic [3:0] lo_reg, lane_reg, oe_reg;
  wire use_wrap = wrap_en_reg && kind_reg == K_QIO;
  wire [7:0] wmask = ~(8'hf8 << wrap_len_reg);
  wire [23:0] addr_inc = rd_addr_reg + 24'h1;
  wire [23:0] addr_adv = use_wrap ?
    {rd_addr_reg[23:8], (rd_addr_reg[7:0] & ~wmask) | (addr_inc[7:0] & wmask)}
    : addr_inc;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rd_req_reg <= 1'b0;
      rd_addr_reg <= 24'h0;
      half_reg <= 1'b0;
      nxt_reg <= 8'h00;
      lo_reg <= 4'h0;
      lane_reg <= 4'h0;
      oe_reg <= 4'h0;
    end else begin
      rd_req_reg <= 1'b0;
      if (arr_rd_valid_i) nxt_reg <= arr_rd_data_i;
      if (dout_enter) begin
        rd_req_reg <= 1'b1;
        rd_addr_reg <= addr_reg;
        half_reg <= 1'b0;
      end
      if (cs_hi) begin
        oe_reg <= 4'h0;
      end else if (fall_e && state_reg == ST_DOUT) begin
        oe_reg <= 4'hf;
        half_reg <= !half_reg;
        if (!half_reg) begin
          lane_reg <= nxt_reg[7:4];
          lo_reg <= nxt_reg[3:0];
          rd_req_reg <= 1'b1;
          rd_addr_reg <= addr_adv;
        end else begin
          lane_reg <= lo_reg;
        end
      end
    end
  end

  // ==========================================
  // outputs
  assign lane_o = lane_reg;
  assign lane_oe_o = oe_reg;
  assign write_unlock_latch_o = unlock_reg;
  assign busy_writing_flag_o = busy_reg;
  assign arr_rd_req_o = rd_req_reg;
  assign arr_rd_addr_o = rd_addr_reg;
  assign arr_wr_valid_o = wr_valid_reg;
  assign arr_wr_o = wr_reg;
  assign erase_req_o = erase_req_reg;
  assign erase_addr_o = erase_addr_reg;

  // ==========================================
  // assertions
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  shift_on_rise_a: assert property (
    !rise_e |=> $stable(sh_reg))
    else $error("shift register moved without a clock rise");
  quad_gate_a: assert property (
    (cmd_done && cmd_w == `QFA_CMD_QIO_READ && !quad_lane_enable_bit_i)
    |=> state_reg == ST_SKIP)
    else $error("quad io read ran with quad enable clear");
  prog_busy_a: assert property (
    prog_go |=> busy_reg && !unlock_reg)
    else $error("program start did not set busy and clear latch");
  busy_latch_a: assert property (
    $rose(busy_reg) |-> !unlock_reg ##1 busy_reg [*3])
    else $error("busy cycle shorter than expected or latch set");
  protect_prog_a: assert property (
    (cs_rise_e && state_reg == ST_PROG && prot_w && !busy_reg)
    |=> !busy_reg)
    else $error("protected page program started");
  wipe_pulse_a: assert property (
    wipe_go |=> erase_req_o && busy_reg && erase_addr_o[11:0] == 12'h000
    ##1 !erase_req_o)
    else $error("erase request wrong");
  wipe_late_a: assert property (
    (rise_e && state_reg == ST_ERASE) |=> state_reg != ST_ERASE)
    else $error("erase kept after extra clock");
  lane_fall_a: assert property (
    $changed(lane_o) |-> $past(fall_e))
    else $error("data lanes changed off a falling edge");
  locked_ignore_a: assert property (
    (cs_rise_e && !unlock_reg && !busy_reg) |=> !busy_reg ##1 !busy_reg)
    else $error("locked command started a cycle");
endmodule // qfa_top
`default_nettype wire

// ===== test/qfa_host.sv
// host-side serial master model driving the flash pins
`timescale 1ns/1ps
`default_nettype none
module qfa_host (
  // serial pins
  output logic cs_n_o,
  output logic sclk_o,
  output logic [3:0] lane_o,
  // device lane drive
  input wire logic [3:0] dev_lane_i,
  input wire logic [3:0] dev_oe_i
);
  logic [3:0] h_val = 4'h0;
  // pin level: a released lane shows the host's own h_val, which rx inverts on each call
  assign lane_o = (dev_oe_i & dev_lane_i) | (~dev_oe_i & h_val);
  // link clock stands low outside frames
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
  end
  // data change while the clock is low, msb first, high nibble first
  task automatic tx(input logic [7:0] b, input bit q, input int nclk);
    for (int i = 0; i < nclk; i++) begin
      if (q) h_val = i[0] ? b[3:0] : b[7:4];
      else h_val[0] = b[7-i];
      #62.5 sclk_o = 1'b1;
      #62.5 sclk_o = 1'b0;
    end
  endtask
  // lanes released for dummies and data; taken just before each rise
  task automatic rx(output logic [7:0] b, input int nclk);
    h_val = ~h_val;
    for (int i = 0; i < nclk; i++) begin
      #62.5 b = {b[3:0], lane_o};
      sclk_o = 1'b1;
      #62.5 sclk_o = 1'b0;
    end
  endtask
  // select stays low for the whole frame, rises only with the clock low
  task automatic sel();
    cs_n_o = 1'b0;
    #62.5;
  endtask
  task automatic desel();
    #62.5 cs_n_o = 1'b1;
    #100;
  endtask
endmodule // qfa_host
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench of the quad spi flash array access block
`timescale 1ns/1ps
`default_nettype none
module tb_top import qfa_pkg::*;;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic quad_en = 1'b0;
  logic dcs = 1'b0;
  logic [4:0] bp = 5'h00;
  logic rd_valid = 1'b0;
  logic wr_ready = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic cs_n, sclk, rd_req, wr_valid, er_req, latch, busy;
  logic [3:0] lane_pin, lane_dev, lane_oe;
  logic [23:0] rd_addr, er_addr, last_er;
  qfa_wr_t wr_w;
  int n_errors = 0, checked = 0, n_wr = 0, n_er = 0, cyc = 0;
  logic [31:0] seed = 32'd57;
  logic [7:0] wmem [logic [23:0]];

  qfa_top #(.PAGE_WRITE_CYCLES(20), .SECTOR_WIPE_CYCLES(40)) qfa_top_inst (
    .clock_i(clock), .srst_i(srst), .cs_n_i(cs_n), .sclk_i(sclk), .lane_i(lane_pin),
    .lane_o(lane_dev), .lane_oe_o(lane_oe), .quad_lane_enable_bit_i(quad_en),
    .dummy_cycle_select_bit_i(dcs), .block_protect_field_i(bp), .write_unlock_latch_o(latch),
    .busy_writing_flag_o(busy), .arr_rd_req_o(rd_req), .arr_rd_addr_o(rd_addr),
    .arr_rd_data_i(rd_data), .arr_rd_valid_i(rd_valid), .arr_wr_valid_o(wr_valid),
    .arr_wr_o(wr_w), .arr_wr_ready_i(wr_ready), .erase_req_o(er_req), .erase_addr_o(er_addr));
  qfa_host qfa_host_inst (.cs_n_o(cs_n), .sclk_o(sclk), .lane_o(lane_pin),
    .dev_lane_i(lane_dev), .dev_oe_i(lane_oe));

  // ==========================================
  // clock and array stand-in
  initial begin
    forever #2 clock = ~clock;
  end
  // read data one clock after the request; program port stalls one cycle in four
  always @(posedge clock) begin
    cyc <= cyc + 1;
    rd_valid <= rd_req;
    rd_data <= mf(rd_addr);
    wr_ready <= (cyc[1:0] != 2'h0);
    if (wr_valid && wr_ready) begin
      wmem[wr_w.addr] = wr_w.data;
      n_wr++;
    end
    if (er_req) begin
      n_er++;
      last_er = er_addr;
    end
  end

  // ==========================================
  // expectations and helpers
  function automatic logic [7:0] mf(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3c;
  endfunction
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // random 24-bit address under a mask
  function automatic logic [23:0] ra(input logic [31:0] m);
    return 24'(rnd() & m);
  endfunction
  // bytes past 256 differ so a kept stale byte shows up
  function automatic logic [7:0] pd(input int i);
    return 8'(i) ^ ((i >= 256) ? 8'ha5 : 8'h00);
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    qfa_host_inst.sel();
    qfa_host_inst.tx(c, 1'b0, 8);
  endtask
  task automatic adr(input logic [23:0] a, input bit q);
    for (int i = 2; i >= 0; i--) qfa_host_inst.tx(a[i*8+:8], q, q ? 2 : 8);
  endtask
  task automatic unlock(input logic [7:0] c);
    cmd(c);
    qfa_host_inst.desel();
    repeat (4) @(posedge clock);
    chk(latch, c == 8'h06);
  endtask
  // bounded wait for the timed cycle to end
  task automatic idle();
    for (int k = 0; k < 3000 && busy !== 1'b0; k++) @(posedge clock);
    chk(busy, 0);
  endtask
  task automatic rd6b(input logic [23:0] a, input int n);
    logic [7:0] b;
    cmd(8'h6b);
    adr(a, 1'b0);
    qfa_host_inst.tx(8'h00, 1'b0, 8);
    for (int i = 0; i < n; i++) begin
      qfa_host_inst.rx(b, 2);
      chk(b, mf(a + 24'(i)));
    end
    qfa_host_inst.desel();
  endtask
  task automatic qio(input logic [23:0] a, input logic [7:0] m, input int n, input bit cont, input int ws);
    logic [7:0] b;
    logic [23:0] e;
    if (cont) qfa_host_inst.sel();
    else cmd(8'heb);
    adr(a, 1'b1);
    qfa_host_inst.tx(m, 1'b1, 2);
    qfa_host_inst.rx(b, dcs ? 8 : 4);
    for (int i = 0; i < n; i++) begin
      qfa_host_inst.rx(b, 2);
      e = ws ? ((a & ~24'(ws - 1)) | ((a + 24'(i)) & 24'(ws - 1))) : a + 24'(i);
      if (quad_en) chk(b, mf(e));
      else chk(lane_oe, 4'h0);
    end
    qfa_host_inst.desel();
  endtask
  task automatic prog(input logic [7:0] c, input logic [23:0] a, input int n, input bit q, input bit cut,
                      input bit ok);
    int w0;
    logic l0;
    wmem.delete();
    w0 = n_wr;
    l0 = latch;
    cmd(c);
    adr(a, 1'b0);
    for (int i = 0; i < n; i++) qfa_host_inst.tx(pd(i), q, q ? 2 : 8);
    if (cut) qfa_host_inst.tx(8'hff, q, q ? 1 : 4);
    qfa_host_inst.desel();
    repeat (8) @(posedge clock);
    chk(busy, ok);
    chk(latch, ok ? 1'b0 : l0);
    idle();
    chk(n_wr - w0, ok ? (n > 256 ? 256 : n) : 0);
    for (int i = (n > 256 ? n - 256 : 0); ok && i < n; i++) chk(wmem[{a[23:8], 8'(a[7:0] + i)}], pd(i));
  endtask
  // cut adds one clock after the address, which must cancel the erase
  task automatic erase(input logic [23:0] a, input bit ok, input bit cut);
    int e0;
    e0 = n_er;
    cmd(8'h20);
    adr(a, 1'b0);
    if (cut) qfa_host_inst.tx(8'h00, 1'b0, 1);
    qfa_host_inst.desel();
    repeat (8) @(posedge clock);
    chk(busy, ok);
    chk(n_er - e0, ok);
    chk(latch, !ok);
    if (ok) chk(last_er, a & 24'hfff000);
    idle();
  endtask
  task automatic results();
    $display("counts: %0d comparisons, %0d mismatches", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================
  // test sequence
  initial begin
    repeat (16) @(posedge clock);
    #1 srst = 1'b0;
    repeat (8) @(posedge clock);
    for (int k = 0; k < 3; k++) rd6b(ra(32'h0fffff), 4);
    $display("test quad output read done");
    qio(24'h001234, 8'h20, 1, 0, 0);
    @(posedge clock) #1 quad_en = 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(posedge clock) #1 dcs = k[0];
      qio(ra(32'h0fffff), 8'h20, 2, 0, 0);
      qio(ra(32'h0fffff), 8'h00, 2, 1, 0);
      rd6b(ra(32'h0fffff), 2);
    end
    $display("test quad io read done");
    // every wrap size, started two bytes before the section end; then wrap off
    for (int w = 0; w < 5; w++) begin
      cmd(8'h77);
      qfa_host_inst.tx(w < 4 ? 8'(w << 5) : 8'h10, 1'b0, 8);
      qfa_host_inst.desel();
      qio(w < 4 ? 24'h0a0300 | 24'((8 << w) - 2) : 24'h0a03fe, 8'h00, 4, 0, w < 4 ? 8 << w : 0);
    end
    $display("test wrap done");
    unlock(8'h04);
    prog(8'h02, 24'h000100, 2, 0, 0, 0);
    unlock(8'h06);
    prog(8'h02, 24'h0123fe, 3, 0, 0, 1);
    unlock(8'h06);
    prog(8'h02, ra(32'h0fffff), 2, 0, 1, 0);
    unlock(8'h06);
    prog(8'h32, ra(32'h0fff00) | 24'h10, 258, 1, 0, 1);
    @(posedge clock) #1 quad_en = 1'b0;
    unlock(8'h06);
    prog(8'h32, 24'h020000, 1, 1, 0, 0);
    $display("test program done");
    @(posedge clock) #1 bp = 5'h01;
    prog(8'h02, 24'h0f1234, 2, 0, 0, 0);
    erase(24'h0f5678, 0, 0);
    @(posedge clock) #1 bp = 5'h00;
    erase(24'h023456, 0, 1);
    erase(24'h012345, 1, 0);
    $display("test erase done");
    results();
  end
  // hang guard, well past the expected run length
  initial begin
    #300000;
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end
endmodule // tb_top
`default_nettype wire
